// File: hw/cbb_bridge_regs.sv
// Contract
// - socket A function reads interrupt pin identifier 01h.
// - socket B function reads interrupt pin identifier 02h.
// - pin identifier is 8-bit read-only; writes leave it unchanged.
// - bridge control bits 15..11 read zero; writes to them ignored.
// - bit 10 set allows posting writes toward and from socket.
// - posting off: drain buffered data before accepting new data.
// - posting off: next source word only after target took previous.
// - posting off: hold source master until target took last word.
// - bit 9 set marks memory window 1 prefetchable, clear not.
// - bit 8 set marks memory window 0 prefetchable, clear not.
// - bridge control reads 0700h after reset.
`timescale 1ns/1ns
`default_nettype none
module cbb_bridge_regs
#(
    parameter int DW = 32
)
(
    input  wire logic          sys_clk,       // 100 MHz clock
    input  wire logic          rst_n,         // sync reset, active low
    input  wire logic          func_sel,      // 0 socket A, 1 socket B
    input  wire logic          cfg_wr,        // config write strobe
    input  wire logic          cfg_rd,        // config read strobe
    input  wire logic [7:0]    cfg_addr,      // config byte address
    input  wire logic [3:0]    cfg_be,        // byte enables
    input  wire logic [31:0]   cfg_wdata,     // write data
    output logic [31:0]        cfg_rdata,     // read data, registered
    output logic               cfg_ack,       // access done, one cycle
    output logic               wpost_en,      // write posting enabled
    output logic               mw1_prefetch,  // window 1 prefetchable
    output logic               mw0_prefetch,  // window 0 prefetchable
    input  wire logic          to_src_valid,  // pci master word valid
    output logic               to_src_ready,  // pci master word taken
    input  wire logic          to_src_last,   // pci master last word
    input  wire logic [DW-1:0] to_src_data,   // pci master data
    output logic               to_src_done,   // pci master released
    output logic               to_dst_valid,  // socket target word valid
    input  wire logic          to_dst_ready,  // socket target accepts
    output logic               to_dst_last,   // socket target last word
    output logic [DW-1:0]      to_dst_data,   // socket target data
    input  wire logic          fr_src_valid,  // card master word valid
    output logic               fr_src_ready,  // card master word taken
    input  wire logic          fr_src_last,   // card master last word
    input  wire logic [DW-1:0] fr_src_data,   // card master data
    output logic               fr_src_done,   // card master released
    output logic               fr_dst_valid,  // pci target word valid
    input  wire logic          fr_dst_ready,  // pci target accepts
    output logic               fr_dst_last,   // pci target last word
    output logic [DW-1:0]      fr_dst_data,   // pci target data
    output logic               path_idle      // both paths empty
);
    logic        wpost_reg;
    logic        wpost_next;
    logic        mw1_reg;
    logic        mw1_next;
    logic        mw0_reg;
    logic        mw0_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ack_reg;
    logic        ack_next;
    logic        hit;
    logic [7:0]  pin_id;
    logic [15:0] ctrl_val;
    logic        to_idle;
    logic        fr_idle;

    ////////////////////////////////////////////////////////////////////////
    // identifier and control word
    cbb_pin_id u_pin_id
    (
        .func_sel (func_sel),
        .pin_id   (pin_id)
    );

    // reserved and lower bits are not stored, so they always read zero
    always_comb
    begin
        ctrl_val = 16'h0000;
        ctrl_val[cbb_pkg::CTRL_WPOST_BIT] = wpost_reg;
        ctrl_val[cbb_pkg::CTRL_MW1_BIT]   = mw1_reg;
        ctrl_val[cbb_pkg::CTRL_MW0_BIT]   = mw0_reg;
    end

    assign hit = (cfg_addr[7:2] == cbb_pkg::CFG_DWORD_OFF[7:2]);

    ////////////////////////////////////////////////////////////////////////
    // control bits
    always_comb
    begin
        wpost_next = wpost_reg;
        mw1_next   = mw1_reg;
        mw0_next   = mw0_reg;
        if (cfg_wr && hit && cfg_be[cbb_pkg::CTRL_HI_LANE])
        begin
            wpost_next = cfg_wdata[16 + cbb_pkg::CTRL_WPOST_BIT];
            mw1_next   = cfg_wdata[16 + cbb_pkg::CTRL_MW1_BIT];
            mw0_next   = cfg_wdata[16 + cbb_pkg::CTRL_MW0_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wpost_reg <= cbb_pkg::CTRL_RESET[cbb_pkg::CTRL_WPOST_BIT];
            mw1_reg   <= cbb_pkg::CTRL_RESET[cbb_pkg::CTRL_MW1_BIT];
            mw0_reg   <= cbb_pkg::CTRL_RESET[cbb_pkg::CTRL_MW0_BIT];
        end
        else
        begin
            wpost_reg <= wpost_next;
            mw1_reg   <= mw1_next;
            mw0_reg   <= mw0_next;
        end
    end

    assign wpost_en     = wpost_reg;
    assign mw1_prefetch = mw1_reg;
    assign mw0_prefetch = mw0_reg;

    ////////////////////////////////////////////////////////////////////////
    // read path; line byte lives elsewhere and reads zero here
    always_comb
    begin
        rdata_next = rdata_reg;
        ack_next   = cfg_rd || cfg_wr;
        if (cfg_rd)
        begin
            rdata_next = 32'h0000_0000;
            if (hit)
                rdata_next = {ctrl_val, pin_id, 8'h00};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cfg_ack   = ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // one gate per direction, both steered by the posting bit
    cbb_post_gate #(.DW(DW)) u_to_sock
    (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .post_en   (wpost_reg),
        .src_valid (to_src_valid),
        .src_ready (to_src_ready),
        .src_last  (to_src_last),
        .src_data  (to_src_data),
        .src_done  (to_src_done),
        .dst_valid (to_dst_valid),
        .dst_ready (to_dst_ready),
        .dst_last  (to_dst_last),
        .dst_data  (to_dst_data),
        .idle      (to_idle)
    );

    cbb_post_gate #(.DW(DW)) u_from_sock
    (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .post_en   (wpost_reg),
        .src_valid (fr_src_valid),
        .src_ready (fr_src_ready),
        .src_last  (fr_src_last),
        .src_data  (fr_src_data),
        .src_done  (fr_src_done),
        .dst_valid (fr_dst_valid),
        .dst_ready (fr_dst_ready),
        .dst_last  (fr_dst_last),
        .dst_data  (fr_dst_data),
        .idle      (fr_idle)
    );

    assign path_idle = to_idle && fr_idle;

    ////////////////////////////////////////////////////////////////////////
    a_pin_sock_a:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_rd && hit && !func_sel) |=> (cfg_rdata[15:8] == 8'h01))
        else $error("socket A pin identifier not 01h");

    a_pin_sock_b:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_rd && hit && func_sel) |=> (cfg_rdata[15:8] == 8'h02))
        else $error("socket B pin identifier not 02h");

    a_pin_read_only:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_wr && hit && cfg_be[1])
                ##2 (cfg_rd && hit && func_sel == $past(func_sel, 2))
                |=> (cfg_rdata[15:8] == ($past(func_sel) ? 8'h02 : 8'h01)))
        else $error("pin identifier changed by write");

    a_pin_upper_zero:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_rd && hit) |=> (cfg_rdata[15:10] == 6'h00))
        else $error("pin identifier upper bits not zero");

    a_rsvd_zero:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_rd && hit) |=> (cfg_rdata[31:27] == 5'h00))
        else $error("reserved control bits not zero");

    a_post_write:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_wr && hit && cfg_be[3])
            |=> (wpost_en == $past(cfg_wdata[26])))
        else $error("posting bit did not take written value");

    a_mw1_write:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_wr && hit && cfg_be[3])
            |=> (mw1_prefetch == $past(cfg_wdata[25])))
        else $error("window 1 attribute did not take written value");

    a_mw0_write:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_wr && hit && cfg_be[3])
            |=> (mw0_prefetch == $past(cfg_wdata[24])))
        else $error("window 0 attribute did not take written value");

    a_reset_value:
        assert property (@(posedge sys_clk)
            !rst_n |=> (ctrl_val == 16'h0700))
        else $error("control not 0700h after reset");

    a_reset_outputs:
        assert property (@(posedge sys_clk)
            !rst_n |=> (wpost_en && mw1_prefetch && mw0_prefetch))
        else $error("control outputs not set after reset");

    a_ctrl_readback:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_rd && hit) |=> (cfg_rdata[31:16] == $past(ctrl_val)))
        else $error("control read differs from stored value");

    a_ctrl_no_be:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (cfg_wr && !(hit && cfg_be[3])) |=> $stable(ctrl_val))
        else $error("control changed without enabled write");

    a_no_post_hold:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && to_dst_valid) |-> !to_src_ready)
        else $error("socket path took word before draining");

    a_fr_drain_first:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && fr_dst_valid) |-> !fr_src_ready)
        else $error("card path took word before draining");

    a_to_word_held:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && to_src_valid && to_src_ready)
            |=> (to_dst_valid && !to_src_ready))
        else $error("socket path took next word before acceptance");

    a_fr_word_held:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && fr_src_valid && fr_src_ready)
            |=> (fr_dst_valid && !fr_src_ready))
        else $error("card path took next word before acceptance");

    a_to_done_late:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && to_src_done)
            |-> (to_dst_valid && to_dst_ready && to_dst_last))
        else $error("socket path released master early");

    a_fr_done_late:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!wpost_en && fr_src_done)
            |-> (fr_dst_valid && fr_dst_ready && fr_dst_last))
        else $error("card path released master early");

    a_to_posted_done:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (wpost_en && to_src_valid && to_src_ready && to_src_last)
            |-> to_src_done)
        else $error("posted socket write not completed");

    a_fr_posted_done:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (wpost_en && fr_src_valid && fr_src_ready && fr_src_last)
            |-> fr_src_done)
        else $error("posted card write not completed");

    c_ctrl_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_wr && hit && cfg_be[3] && !cfg_wdata[26]);

    c_pin_read_b: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_rd && hit && func_sel);

    c_from_nonposted: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !wpost_en && fr_src_done);
endmodule
`default_nettype wire

// File: hw/cbb_pkg.sv
package cbb_pkg;
    // configuration dword holding line, pin and bridge control bytes
    localparam logic [7:0]  CFG_DWORD_OFF  = 8'h3C;
    localparam logic [7:0]  PIN_OFF        = 8'h3D;
    localparam logic [7:0]  CTRL_OFF       = 8'h3E;
    // byte lanes of that dword
    localparam int          PIN_LANE       = 1;
    localparam int          CTRL_LO_LANE   = 2;
    localparam int          CTRL_HI_LANE   = 3;
    // interrupt pin identifier per socket function
    localparam logic [7:0]  PIN_ID_SOCK_A  = 8'h01;
    localparam logic [7:0]  PIN_ID_SOCK_B  = 8'h02;
    // bridge control layout
    localparam logic [15:0] CTRL_RESET     = 16'h0700;
    localparam int          CTRL_RSVD_MSB  = 15;
    localparam int          CTRL_RSVD_LSB  = 11;
    localparam int          CTRL_WPOST_BIT = 10;
    localparam int          CTRL_MW1_BIT   = 9;
    localparam int          CTRL_MW0_BIT   = 8;
endpackage

// File: hw/cbb_pin_id.sv
`timescale 1ns/1ns
`default_nettype none
module cbb_pin_id
(
    input  wire logic       func_sel,   // 0 socket A, 1 socket B
    output logic [7:0]      pin_id      // interrupt pin identifier
);
    // constant per function, no storage so no write can alter it
    always_comb
    begin
        if (func_sel)
            pin_id = cbb_pkg::PIN_ID_SOCK_B;
        else
            pin_id = cbb_pkg::PIN_ID_SOCK_A;
    end
endmodule
`default_nettype wire

// File: hw/cbb_post_gate.sv
`timescale 1ns/1ns
`default_nettype none
module cbb_post_gate
#(
    parameter int DW = 32
)
(
    input  wire logic          sys_clk,    // clock
    input  wire logic          rst_n,      // sync reset
    input  wire logic          post_en,    // write posting enabled
    input  wire logic          src_valid,  // master offers a word
    output logic               src_ready,  // word taken from master
    input  wire logic          src_last,   // final word of transaction
    input  wire logic [DW-1:0] src_data,   // word from master
    output logic               src_done,   // master released
    output logic               dst_valid,  // word offered to target
    input  wire logic          dst_ready,  // target accepts word
    output logic               dst_last,   // final word to target
    output logic [DW-1:0]      dst_data,   // word to target
    output logic               idle        // nothing held
);
    logic          hold_valid_reg;
    logic          hold_valid_next;
    logic          hold_last_reg;
    logic          hold_last_next;
    logic          hold_np_reg;
    logic          hold_np_next;
    logic [DW-1:0] hold_data_reg;
    logic [DW-1:0] hold_data_next;
    logic          src_fire;
    logic          dst_fire;

    ////////////////////////////////////////////////////////////////////////
    // posted: pipeline slot; non-posted: one word in flight at a time
    always_comb
    begin
        dst_fire = hold_valid_reg && dst_ready;
        if (post_en && !hold_np_reg)
            src_ready = !hold_valid_reg || dst_ready;
        else
            src_ready = !hold_valid_reg;
        src_fire        = src_valid && src_ready;
        hold_valid_next = hold_valid_reg;
        hold_last_next  = hold_last_reg;
        hold_np_next    = hold_np_reg;
        hold_data_next  = hold_data_reg;
        if (dst_fire)
            hold_valid_next = 1'b0;
        if (src_fire)
        begin
            hold_valid_next = 1'b1;
            hold_last_next  = src_last;
            hold_np_next    = !post_en;
            hold_data_next  = src_data;
        end
        // non-posted master waits for the target to take the last word
        src_done = (src_fire && src_last && post_en)
                 || (dst_fire && hold_last_reg && hold_np_reg);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hold_valid_reg <= 1'b0;
            hold_last_reg  <= 1'b0;
            hold_np_reg    <= 1'b0;
            hold_data_reg  <= '0;
        end
        else
        begin
            hold_valid_reg <= hold_valid_next;
            hold_last_reg  <= hold_last_next;
            hold_np_reg    <= hold_np_next;
            hold_data_reg  <= hold_data_next;
        end
    end

    assign dst_valid = hold_valid_reg;
    assign dst_last  = hold_last_reg;
    assign dst_data  = hold_data_reg;
    assign idle      = !hold_valid_reg;

    ////////////////////////////////////////////////////////////////////////
    a_drain_before_take:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (!post_en && hold_valid_reg) |-> !src_ready)
        else $error("word taken while buffer not drained");

    a_word_lockstep:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (src_fire && !post_en) |=> (!src_ready until_with dst_fire))
        else $error("next word taken before target accepted previous");

    a_lockstep_bound:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (src_fire && !post_en)
            |=> (dst_valid && dst_data == $past(src_data)))
        else $error("taken word not offered to target");

    a_release_late:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (src_fire && src_last && !post_en) |-> !src_done)
        else $error("non-posted master released on acceptance");

    a_release_on_take:
        assert property (@(posedge sys_clk) disable iff (!rst_n)
            (dst_fire && hold_last_reg && hold_np_reg) |-> src_done)
        else $error("master not released when last word taken");

    c_nonposted_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
        src_fire && !post_en ##[1:8] dst_fire && src_done);

    c_posted_burst: cover property (@(posedge sys_clk) disable iff (!rst_n)
        src_fire && dst_fire && post_en);
endmodule
`default_nettype wire

// File: verif/cbb_tgt_model.sv
`timescale 1ns/1ns
`default_nettype none
module cbb_tgt_model
(
    input  wire logic        sys_clk,    // clock
    input  wire logic        rst_n,      // sync reset
    input  wire logic        dst_valid,  // word offered
    input  wire logic [31:0] dst_data,   // offered word
    input  wire logic [3:0]  wait_cyc,   // stall before accept
    output logic             dst_ready,  // accept strobe
    output logic [31:0]      acc_data,   // last word taken
    output logic [7:0]       acc_cnt     // words taken
);
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [31:0] data_reg;
    logic [31:0] data_next;
    logic [7:0]  num_reg;
    logic [7:0]  num_next;
    // ready only while a word is offered, never left over from the last one
    assign dst_ready = dst_valid && (cnt_reg == wait_cyc);
    assign acc_data  = data_reg;
    assign acc_cnt   = num_reg;
    always_comb
    begin
        cnt_next  = 4'h0;
        data_next = data_reg;
        num_next  = num_reg;
        if (dst_valid && !dst_ready)
            cnt_next = cnt_reg + 4'h1;
        if (dst_valid && dst_ready)
        begin
            data_next = dst_data;
            num_next  = num_reg + 8'h01;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cnt_reg  <= 4'h0;
            data_reg <= 32'h0;
            num_reg  <= 8'h00;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            data_reg <= data_next;
            num_reg  <= num_next;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_cbb_bridge_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cbb_bridge_regs;
    logic        sys_clk, rst_n, func_sel, cfg_wr, cfg_rd;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    wire  [31:0] cfg_rdata;
    wire         cfg_ack, wpost_en, mw1_prefetch, mw0_prefetch, path_idle;
    logic [1:0]  s_valid, s_last;
    logic [31:0] s_data [2];
    wire  [1:0]  s_ready, s_done, d_valid, d_ready, d_last;
    wire  [31:0] d_data [2];
    wire  [31:0] acc_data [2];
    wire  [7:0]  acc_cnt [2];
    logic [3:0]  wt [2];
    int          miscompares, n_tests;
    cbb_bridge_regs #(.DW(32)) i_cbb_bridge_regs (.sys_clk(sys_clk),
        .rst_n(rst_n), .func_sel(func_sel), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wpost_en(wpost_en),
        .mw1_prefetch(mw1_prefetch), .mw0_prefetch(mw0_prefetch),
        .to_src_valid(s_valid[0]), .to_src_ready(s_ready[0]),
        .to_src_last(s_last[0]), .to_src_data(s_data[0]),
        .to_src_done(s_done[0]), .to_dst_valid(d_valid[0]),
        .to_dst_ready(d_ready[0]), .to_dst_last(d_last[0]),
        .to_dst_data(d_data[0]), .fr_src_valid(s_valid[1]),
        .fr_src_ready(s_ready[1]), .fr_src_last(s_last[1]),
        .fr_src_data(s_data[1]), .fr_src_done(s_done[1]),
        .fr_dst_valid(d_valid[1]), .fr_dst_ready(d_ready[1]),
        .fr_dst_last(d_last[1]), .fr_dst_data(d_data[1]),
        .path_idle(path_idle));
    for (genvar g = 0; g < 2; g++)
    begin : g_tgt
        cbb_tgt_model i_cbb_tgt_model (.sys_clk(sys_clk), .rst_n(rst_n),
            .dst_valid(d_valid[g]), .dst_data(d_data[g]),
            .wait_cyc(wt[g]), .dst_ready(d_ready[g]),
            .acc_data(acc_data[g]), .acc_cnt(acc_cnt[g]));
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // entered at a falling edge; strobe lasts one cycle, answer one later
    task automatic cfg(input logic wr, input logic [3:0] be,
                       input logic [31:0] wd, input logic [7:0] a = 8'h3C);
        cfg_wr = wr;
        cfg_rd = ~wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        @(negedge sys_clk);
        check("cfg_ack", 32'(cfg_ack), 32'h1);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        @(negedge sys_clk);
    endtask
    // valid left high on return so the next word can follow back to back
    task automatic send(input int p, input logic [31:0] d, input logic l,
                        output int w, output logic dn);
        w = 0;
        s_valid[p] = 1'b1;
        s_data[p] = d;
        s_last[p] = l;
        #1;
        while (s_ready[p] !== 1'b1 && w < 50)
        begin
            @(negedge sys_clk);
            #1;
            w++;
        end
        check("src ready", 32'(s_ready[p]), 32'h1);
        dn = s_done[p];
        @(negedge sys_clk);
    endtask
    task automatic finish_last(input int p);
        int k;
        k = 0;
        s_valid[p] = 1'b0;
        #1;
        while (s_done[p] !== 1'b1 && k < 30)
        begin
            @(negedge sys_clk);
            #1;
            k++;
        end
        check("done seen", 32'(s_done[p]), 32'h1);
        check("done at accept", 32'(d_valid[p] & d_ready[p] & d_last[p]),
              32'h1);
        @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [2:0] v;
        cfg(1'b0, 4'hF, 32'h0);
        check("dword A", cfg_rdata, {cbb_pkg::CTRL_RESET,
              cbb_pkg::PIN_ID_SOCK_A, 8'h00});
        check("ctrl outs", 32'({wpost_en, mw1_prefetch, mw0_prefetch}),
              32'h7);
        func_sel = 1'b1;
        cfg(1'b1, 4'h7, 32'hFFFF_FFFF);
        cfg(1'b0, 4'hF, 32'h0);
        check("dword B", cfg_rdata, {cbb_pkg::CTRL_RESET,
              cbb_pkg::PIN_ID_SOCK_B, 8'h00});
        for (int i = 0; i < 8; i++)
        begin
            v = 3'(i);
            cfg(1'b1, 4'h8, {5'h1F, v, 24'hFF_FFFF});
            cfg(1'b0, 4'hF, 32'h0);
            check("ctrl", 32'(cfg_rdata[31:16]),
                  {16'h0, 5'h00, v, 8'h00});
            check("ctrl outs", 32'({wpost_en, mw1_prefetch, mw0_prefetch}),
                  32'(v));
        end
        cfg(1'b1, 4'hF, 32'h0, 8'h40);
        cfg(1'b0, 4'hF, 32'h0, 8'h40);
        check("unmapped", cfg_rdata, 32'h0);
        cfg(1'b0, 4'hF, 32'h0);
        check("ctrl kept", 32'(cfg_rdata[31:16]), 32'h0700);
        func_sel = 1'b0;
        $display("test regs done");
    endtask
    task automatic t_posted();
        int w;
        logic dn;
        logic [7:0] c0;
        wt[0] = 4'h0;
        c0 = acc_cnt[0];
        for (int i = 0; i < 3; i++)
        begin
            send(0, 32'(i), i == 2, w, dn);
            check("posted wait", 32'(w), 32'h0);
            check("posted done", 32'(dn), 32'(i == 2));
        end
        s_valid[0] = 1'b0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check("posted count", 32'(acc_cnt[0]), 32'(c0 + 8'h03));
        check("posted data", acc_data[0], 32'h2);
        $display("test posted done");
    endtask
    task automatic t_nonposted(input int p);
        int w;
        logic dn;
        logic [7:0] c0;
        wt[p] = 4'h3;
        cfg(1'b1, 4'h8, 32'h0);
        c0 = acc_cnt[p];
        send(p, 32'hA5A5_0001, 1'b0, w, dn);
        send(p, 32'h5A5A_0002, 1'b1, w, dn);
        check("word gap", 32'(w >= 3), 32'h1);
        check("early done", 32'(dn), 32'h0);
        finish_last(p);
        check("np count", 32'(acc_cnt[p]), 32'(c0 + 8'h02));
        check("np data", acc_data[p], 32'h5A5A_0002);
        check("idle", 32'(path_idle), 32'h1);
        $display("test nonposted %0d done", p);
    endtask
    task automatic t_drain();
        int w;
        logic dn;
        logic [7:0] c0;
        wt[1] = 4'h6;
        cfg(1'b1, 4'h8, 32'h0700_0000);
        c0 = acc_cnt[1];
        send(1, 32'hC0DE_0001, 1'b1, w, dn);
        check("posted done", 32'(dn), 32'h1);
        s_valid[1] = 1'b0;
        cfg(1'b1, 4'h8, 32'h0);
        send(1, 32'hBEEF_0002, 1'b1, w, dn);
        check("drained first", 32'(acc_cnt[1]), 32'(c0 + 8'h01));
        finish_last(1);
        check("drain data", acc_data[1], 32'hBEEF_0002);
        $display("test drain done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #50000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        miscompares = 0;
        n_tests = 0;
        rst_n = 1'b0;
        func_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        s_valid = 2'b00;
        s_last = 2'b00;
        s_data[0] = 32'h0;
        s_data[1] = 32'h0;
        wt[0] = 4'h0;
        wt[1] = 4'h0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        t_regs();
        cfg(1'b1, 4'h8, 32'h0700_0000);
        t_posted();
        t_nonposted(0);
        t_nonposted(1);
        t_drain();
        print_verdict();
    end
endmodule
`default_nettype wire
